/* logic/sgc_regs.vh */
// Register offsets, reset values, field positions and timing counts of the pin block
`ifndef SGC_REGS_VH
`define SGC_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SGC_OFS_LOCAL_OUT     8'h0D
`define SGC_OFS_DIR_CTRL      8'h0E
`define SGC_OFS_FWD_CNT_EN    8'h33
`define SGC_OFS_LEVEL_STS     8'h53

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SGC_RST_LOCAL_OUT     8'h00
`define SGC_RST_DIR_CTRL      8'h0F
`define SGC_RST_FWD_CNT_EN    8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SGC_DIR_IN_EN_LO      0
`define SGC_DIR_OUT_EN_LO     4
`define SGC_LOC_VALUE_LO      0
`define SGC_LOC_REMOTE_LO     4
`define SGC_FWD_COUNT_LO      0
`define SGC_FWD_ENABLE_BIT    3

// ---------------------------------------------------------------
// Forward sampling periods in forward frames
// ---------------------------------------------------------------
`define SGC_FWD_PERIOD_ONE    3'h1
`define SGC_FWD_PERIOD_TWO    3'h2
`define SGC_FWD_PERIOD_MANY   3'h5

// ---------------------------------------------------------------
// Clock and back-channel sampling rates
// ---------------------------------------------------------------
`define SGC_CLK_HZ            25000000
`define SGC_BC_RATE_SYNC_HZ   1670000
`define SGC_BC_RATE_NSYNC_HZ  334000
`define SGC_BC_RATE_PAR_HZ    83500
`define SGC_BC_DIV_SYNC       (`SGC_CLK_HZ / `SGC_BC_RATE_SYNC_HZ)
`define SGC_BC_DIV_NSYNC      (`SGC_CLK_HZ / `SGC_BC_RATE_NSYNC_HZ)
`define SGC_BC_DIV_PAR        (`SGC_CLK_HZ / `SGC_BC_RATE_PAR_HZ)

// ---------------------------------------------------------------
// Clocking mode codes
// ---------------------------------------------------------------
`define SGC_MODE_SYNC         2'h0
`define SGC_MODE_NSYNC        2'h1
`define SGC_MODE_PARALLEL     2'h2

`endif

/* logic/sgc_gpio.v */
// Four-pin general-purpose I/O block of the link serializer
//
// How it works
// - Four pins, configured through registers
// - Status bit shows level when input enabled
// - Output-only pin status bit is not functional
// - Input enable connects internal pull-down
// - All pins inputs after reset
// - Input enables in bits 3:0
// - Output enable bits 7:4 drive pin
// - Forward up to four pin levels
// - One forwarded pin: sample every frame
// - Two: every two frames; more: five
// - Output pin may drive back-channel data
// - Back-channel sampling rate follows clock mode
// - Pins 0 and 1 support voltage sensing
`timescale 1ns/1ps
`include "sgc_regs.vh"

module sgc_gpio (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Register access port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Pins
  input  wire [3:0] pin_in,
  output reg  [3:0] pin_out,
  output reg  [3:0] pin_oe,
  output reg  [3:0] pin_pd_en,
  // Voltage sense on pins 0 and 1
  input  wire [1:0] diag_sense_en,
  output reg  [1:0] vsense_route,
  // Forward channel
  input  wire       fc_frame_strobe,
  output reg  [3:0] fc_gpio_data,
  output reg  [2:0] fc_gpio_count,
  output reg        fc_gpio_valid,
  // Back channel
  input  wire [1:0] clk_mode,
  input  wire [3:0] bc_gpio_data
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  reg       rst_meta_ff;
  reg       rst_sync_ff;
  wire      rst_n;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [7:0] local_out_ff;
  reg  [7:0] dir_ctrl_ff;
  reg  [7:0] fwd_cnt_en_ff;
  wire [3:0] in_en;
  wire [3:0] out_en;
  wire [3:0] loc_value;
  wire [3:0] loc_remote;
  wire [2:0] fwd_count;
  wire       fwd_enable;
  wire [7:0] level_status;

  assign in_en      = dir_ctrl_ff[`SGC_DIR_IN_EN_LO +: 4];
  assign out_en     = dir_ctrl_ff[`SGC_DIR_OUT_EN_LO +: 4];
  assign loc_value  = local_out_ff[`SGC_LOC_VALUE_LO +: 4];
  assign loc_remote = local_out_ff[`SGC_LOC_REMOTE_LO +: 4];
  assign fwd_count  = fwd_cnt_en_ff[`SGC_FWD_COUNT_LO +: 3];
  assign fwd_enable = fwd_cnt_en_ff[`SGC_FWD_ENABLE_BIT];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      local_out_ff  <= `SGC_RST_LOCAL_OUT;
      dir_ctrl_ff   <= `SGC_RST_DIR_CTRL;
      fwd_cnt_en_ff <= `SGC_RST_FWD_CNT_EN;
    end else if (reg_wr) begin
      case (reg_addr)
        `SGC_OFS_LOCAL_OUT: begin
          local_out_ff <= reg_wdata;
        end
        `SGC_OFS_DIR_CTRL: begin
          dir_ctrl_ff <= reg_wdata;
        end
        `SGC_OFS_FWD_CNT_EN: begin
          fwd_cnt_en_ff <= reg_wdata;
        end
        default: begin
          local_out_ff <= local_out_ff;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SGC_OFS_LOCAL_OUT:  reg_rdata <= local_out_ff;
        `SGC_OFS_DIR_CTRL:   reg_rdata <= dir_ctrl_ff;
        `SGC_OFS_FWD_CNT_EN: reg_rdata <= fwd_cnt_en_ff;
        `SGC_OFS_LEVEL_STS:  reg_rdata <= level_status;
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin input synchroniser
  // ---------------------------------------------------------------
  reg  [3:0] pin_s1_ff;
  reg  [3:0] pin_s2_ff;
  reg  [3:0] pin_s3_ff;
  reg  [3:0] pin_lvl_ff;
  wire [3:0] dig_in_ok;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff  <= 4'h0;
      pin_s2_ff  <= 4'h0;
      pin_s3_ff  <= 4'h0;
      pin_lvl_ff <= 4'h0;
    end else begin
      pin_s1_ff  <= pin_in;
      pin_s2_ff  <= pin_s1_ff;
      pin_s3_ff  <= pin_s2_ff;
      pin_lvl_ff <= (pin_s2_ff & ~(pin_s2_ff ^ pin_s3_ff)) |
                    (pin_lvl_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  // Pins under voltage sense have no digital input
  assign dig_in_ok = in_en & ~{2'b00, diag_sense_en};

  // Status reads zero where the input path is off
  assign level_status = {4'h0, pin_lvl_ff & dig_in_ok};

  // ---------------------------------------------------------------
  // Back-channel sampling
  // ---------------------------------------------------------------
  reg  [8:0] bc_div_ff;
  reg  [3:0] bc_remote_ff;
  wire [8:0] bc_div_top;

  function [8:0] bc_divider;
    input   [1:0] mode;
    integer       div;
    begin
      case (mode)
        `SGC_MODE_SYNC:  div = `SGC_BC_DIV_SYNC;
        `SGC_MODE_NSYNC: div = `SGC_BC_DIV_NSYNC;
        default:         div = `SGC_BC_DIV_PAR;
      endcase
      // All divider counts fit in nine bits
      bc_divider = div[8:0];
    end
  endfunction

  assign bc_div_top = bc_divider(clk_mode) - 9'd1;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bc_div_ff    <= 9'd0;
      bc_remote_ff <= 4'h0;
    end else if (bc_div_ff >= bc_div_top) begin
      bc_div_ff    <= 9'd0;
      bc_remote_ff <= bc_gpio_data;
    end else begin
      bc_div_ff <= bc_div_ff + 9'd1;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  wire [3:0] drive_en;
  wire [3:0] nxt_pin_out;

  assign drive_en    = out_en & ~{2'b00, diag_sense_en};
  assign nxt_pin_out = (loc_remote & bc_remote_ff) | (~loc_remote & loc_value);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out      <= 4'h0;
      pin_oe       <= 4'h0;
      pin_pd_en    <= 4'h0;
      vsense_route <= 2'b00;
    end else begin
      pin_out      <= nxt_pin_out & drive_en;
      pin_oe       <= drive_en;
      pin_pd_en    <= in_en;
      vsense_route <= diag_sense_en;
    end
  end

  // ---------------------------------------------------------------
  // Forward-channel sampling
  // ---------------------------------------------------------------
  reg  [2:0] fc_frame_ff;
  reg  [2:0] fc_period;
  reg  [3:0] fc_mask;
  wire       fc_active;

  always @* begin
    case (fwd_count)
      3'd1: begin
        fc_period = `SGC_FWD_PERIOD_ONE;
        fc_mask   = 4'h1;
      end
      3'd2: begin
        fc_period = `SGC_FWD_PERIOD_TWO;
        fc_mask   = 4'h3;
      end
      3'd3: begin
        fc_period = `SGC_FWD_PERIOD_MANY;
        fc_mask   = 4'h7;
      end
      3'd4: begin
        fc_period = `SGC_FWD_PERIOD_MANY;
        fc_mask   = 4'hF;
      end
      default: begin
        fc_period = `SGC_FWD_PERIOD_ONE;
        fc_mask   = 4'h0;
      end
    endcase
  end

  assign fc_active = fwd_enable && (fc_mask != 4'h0);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_frame_ff   <= 3'd0;
      fc_gpio_data  <= 4'h0;
      fc_gpio_count <= 3'd0;
      fc_gpio_valid <= 1'b0;
    end else begin
      fc_gpio_valid <= 1'b0;
      if (!fc_active) begin
        fc_frame_ff <= 3'd0;
      end else if (fc_frame_strobe) begin
        if (fc_frame_ff == 3'd0) begin
          fc_gpio_data  <= pin_lvl_ff & dig_in_ok & fc_mask;
          fc_gpio_count <= fwd_count;
          fc_gpio_valid <= 1'b1;
        end
        if (fc_frame_ff >= fc_period - 3'd1) begin
          fc_frame_ff <= 3'd0;
        end else begin
          fc_frame_ff <= fc_frame_ff + 3'd1;
        end
      end
    end
  end

endmodule

/* verification/sgc_deser_model.sv */
// Far-side link model: forward frame strobes and a changing back-channel pattern
`timescale 1ns/1ps
module sgc_deser_model (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Link side
  output reg        fc_frame_strobe,
  output reg  [3:0] bc_gpio_data
);
  reg [1:0] frame_ff;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_ff        <= 2'h0;
      fc_frame_strobe <= 1'b0;
      bc_gpio_data    <= 4'h0;
    end else begin
      frame_ff        <= frame_ff + 2'h1;
      // One forward frame every four clocks
      fc_frame_strobe <= (frame_ff == 2'h3);
      // New remote value every clock, so each back-channel sample differs
      bc_gpio_data    <= bc_gpio_data + 4'h1;
    end
  end
endmodule

/* verification/sgc_gpio_monitor.sv */
// Checker for the pin block, bound to its ports
`timescale 1ns/1ps
module sgc_gpio_monitor (
  // Clock, reset, register port
  input wire       clk,
  input wire       resetn,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Pins
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe,
  input wire [3:0] pin_pd_en,
  input wire [1:0] diag_sense_en,
  // Forward channel
  input wire       fc_frame_strobe,
  input wire [3:0] fc_gpio_data,
  input wire [2:0] fc_gpio_count,
  input wire       fc_gpio_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Direction write followed by a quiet cycle
  sequence s_dir_wr;
    reg_wr && reg_addr == 8'h0E && diag_sense_en == 2'h0 ##1 !(reg_wr && reg_addr == 8'h0E);
  endsequence
  a_dir_out_en: assert property (s_dir_wr |=> pin_oe == $past(reg_wdata[7:4], 2))
    else $error("pin_oe differs from written enables");
  a_pull_down: assert property (s_dir_wr |=> pin_pd_en == $past(reg_wdata[3:0], 2))
    else $error("pin_pd_en differs from written enables");
  a_undriven_zero: assert property ((pin_out & ~pin_oe) == 4'h0)
    else $error("pin_out high on undriven pin");
  a_fwd_pulse: assert property (fc_gpio_valid |=> !fc_gpio_valid)
    else $error("fc_gpio_valid longer than one cycle");
  a_fwd_cause: assert property (fc_gpio_valid |-> $past(fc_frame_strobe))
    else $error("fc_gpio_valid without frame strobe");
  a_fwd_count: assert property (fc_gpio_valid |-> fc_gpio_count inside {[3'h1:3'h4]})
    else $error("fc_gpio_count out of range");
  a_fwd_mask: assert property (fc_gpio_valid && fc_gpio_count < 3'h4 |->
    (fc_gpio_data >> fc_gpio_count) == 4'h0)
    else $error("fc_gpio_data beyond forwarded pins");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h0D, 8'h0E, 8'h33, 8'h53})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sense_undriven: assert property (diag_sense_en[0] [*3] |-> !pin_oe[0])
    else $error("pin 0 driven during voltage sense");
endmodule
bind sgc_gpio sgc_gpio_monitor u_mon (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .pin_out, .pin_oe, .pin_pd_en, .diag_sense_en, .fc_frame_strobe, .fc_gpio_data,
  .fc_gpio_count, .fc_gpio_valid);

/* verification/test_sgc_gpio.sv */
// Self-checking bench for the pin block
`timescale 1ns/1ps
`include "sgc_regs.vh"
module test_sgc_gpio;
  reg        clk, resetn, reg_wr, reg_rd;
  reg  [7:0] reg_addr, reg_wdata;
  reg  [3:0] ext_lvl;
  reg  [1:0] diag_sense_en, clk_mode;
  wire [7:0] reg_rdata;
  wire [3:0] pin_in, pin_out, pin_oe, pin_pd_en, fc_gpio_data, bc_gpio_data;
  wire [2:0] fc_gpio_count;
  wire [1:0] vsense_route;
  wire       fc_frame_strobe, fc_gpio_valid;
  integer    n_fail, n_checks, i, k, n;
  reg  [3:0] last;
  // Driven pins read back their own value, the rest the external level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  sgc_gpio u_dut (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pin_in,
    .pin_out, .pin_oe, .pin_pd_en, .diag_sense_en, .vsense_route, .fc_frame_strobe,
    .fc_gpio_data, .fc_gpio_count, .fc_gpio_valid, .clk_mode, .bc_gpio_data);
  sgc_deser_model u_far (.clk, .resetn, .fc_frame_strobe, .bc_gpio_data);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task step;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      step;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      step;
      chk(16'(reg_rdata), 16'(exp));
    end
  endtask
  task t_reset;
    begin
      rd(8'h0D, 8'h00);
      rd(8'h0E, 8'h0F);
      rd(8'h33, 8'h00);
      rd(8'h40, 8'h00);
      chk(16'(pin_pd_en), 16'h000F);
      chk(16'(pin_oe), 16'h0000);
    end
  endtask
  task t_status;
    begin
      @(posedge clk);
      ext_lvl <= 4'hA;
      repeat (6) step;
      rd(8'h53, 8'h0A);
      @(posedge clk);
      ext_lvl <= 4'hF;
      wr(8'h0D, 8'h03);
      wr(8'h0E, 8'h31);
      chk(16'(pin_oe), 16'h0003);
      chk(16'(pin_out), 16'h0003);
      chk(16'(pin_pd_en), 16'h0001);
      repeat (5) step;
      rd(8'h53, 8'h01);
      wr(8'h0D, 8'h02);
      repeat (5) step;
      rd(8'h53, 8'h00);
      @(posedge clk);
      diag_sense_en <= 2'h1;
      repeat (4) step;
      chk(16'(pin_oe), 16'h0002);
      chk(16'(vsense_route), 16'h0001);
      @(posedge clk);
      diag_sense_en <= 2'h2;
      repeat (4) step;
      chk(16'(pin_oe), 16'h0001);
      chk(16'(vsense_route), 16'h0002);
      @(posedge clk);
      diag_sense_en <= 2'h0;
      wr(8'h0E, 8'h00);
      chk(16'(pin_out), 16'h0000);
    end
  endtask
  task t_remote;
    begin
      wr(8'h0E, 8'hF0);
      wr(8'h0D, 8'hF0);
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge clk);
        clk_mode <= i[1:0];
        repeat (600) step;
        // First pass aligns to a sample, second pass measures one period
        for (n = 0; n < 2; n = n + 1) begin
          last = pin_out;
          k = 0;
          while (pin_out === last && k < 400) begin
            step;
            k = k + 1;
          end
        end
        chk(16'(k), (i == 0) ? 16'(`SGC_BC_DIV_SYNC) : (i == 1) ? 16'(`SGC_BC_DIV_NSYNC) :
          16'(`SGC_BC_DIV_PAR));
      end
    end
  endtask
  task t_forward;
    begin
      wr(8'h0E, 8'h0F);
      // Steady pattern, far below a quarter of the forward sampling rate
      @(posedge clk);
      ext_lvl <= 4'h5;
      repeat (6) step;
      for (i = 0; i <= 4; i = i + 1) begin
        wr(8'h33, 8'h08 | i[7:0]);
        n = 0;
        while (fc_gpio_valid !== 1'b1 && n < 60) begin
          step;
          n = n + 1;
        end
        if (i == 0) begin
          chk(16'(n), 16'd60);
        end else begin
          chk(16'(fc_gpio_count), 16'(i));
          chk(16'(fc_gpio_data), 16'(4'h5 & (4'hF >> (4 - i))));
          k = 0;
          n = 0;
          step;
          while (fc_gpio_valid !== 1'b1 && n < 60) begin
            if (fc_frame_strobe === 1'b1) k = k + 1;
            step;
            n = n + 1;
          end
          chk(16'(k), (i == 1) ? 16'd1 : (i == 2) ? 16'd2 : 16'd5);
        end
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #(40 * 20000);
    n_fail = n_fail + 1;
    final_report;
  end
  initial begin
    n_fail = 0;
    n_checks = 0;
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h0;
    {ext_lvl, diag_sense_en, clk_mode} = 8'h00;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) step;
    t_reset;
    t_status;
    t_remote;
    t_forward;
    final_report;
  end
endmodule
